// ===== core/wwdt_pkg.sv
// Shared constants, register map and types of the windowed watchdog.
package wwdt_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets on the AHB-Lite slave.
    // ------------------------------------------------------------------
    localparam logic [7:0] WWDT_OFS_RESET_CONTROL_REG   = 8'h00; // Reset control register.
    localparam logic [7:0] WWDT_OFS_CONFIG = 8'h04; // Watchdog config word.
    localparam logic [7:0] WWDT_OFS_STATUS = 8'h08; // Live counter status.

    // ------------------------------------------------------------------
    // Field positions.
    // ------------------------------------------------------------------
    localparam int WWDT_RESET_CONTROL_REG_SWEN_BIT  = 5; // Software enable.
    localparam int WWDT_RESET_CONTROL_REG_TMO_BIT   = 4; // Time-out flag.
    localparam int WWDT_RESET_CONTROL_REG_SLEEP_BIT = 3; // Woke from Sleep flag.
    localparam int WWDT_RESET_CONTROL_REG_IDLE_BIT  = 2; // Woke from Idle flag.
    localparam int WWDT_CFG_POST_LSB   = 0; // Postscale select, 4 bits.
    localparam int WWDT_CFG_POST_W     = 4; // Width of postscale select.
    localparam int WWDT_CFG_PRESEL_BIT = 4; // Prescale select, 1 = /128.
    localparam int WWDT_CFG_WINDOW_DISABLE_BIT = 6; // Window disable.
    localparam int WWDT_CFG_HWEN_BIT   = 7; // Hardware watchdog enable.
    localparam int WWDT_STAT_PRE_LSB   = 0; // Prescaler count, 7 bits.
    localparam int WWDT_STAT_POST_LSB  = 8; // Postscaler count, 16 bits.
    localparam int WWDT_STAT_PS_LSB    = 24; // Power state, 2 bits.
    localparam int WWDT_STAT_EN_BIT    = 28; // Watchdog running.

    // ------------------------------------------------------------------
    // Values after reset.
    // ------------------------------------------------------------------
    localparam logic [7:0] WWDT_CFG_RESET  = 8'h5f; // 1:32768, /128, no window.
    localparam logic [7:0] WWDT_RESET_CONTROL_REG_RESET = 8'h00; // All flags and enable 0.

    // ------------------------------------------------------------------
    // Oscillator and prescaler timing.
    // ------------------------------------------------------------------
    localparam int WWDT_LOW_POWER_RC_OSC_HZ      = 32000; // Nominal oscillator rate.
    localparam int WWDT_T_SHORT_US   = 1000;  // Basic period, 5-bit mode.
    localparam int WWDT_T_LONG_US    = 4000;  // Basic period, 7-bit mode.
    localparam int WWDT_PRE_DIV_SHORT =
        WWDT_LOW_POWER_RC_OSC_HZ / 1000 * WWDT_T_SHORT_US / 1000;
    localparam int WWDT_PRE_DIV_LONG  =
        WWDT_LOW_POWER_RC_OSC_HZ / 1000 * WWDT_T_LONG_US / 1000;
    localparam int WWDT_PRE_SH_SHORT = $clog2(WWDT_PRE_DIV_SHORT);
    localparam int WWDT_PRE_SH_LONG  = $clog2(WWDT_PRE_DIV_LONG);
    localparam int WWDT_PRE_W        = 8;  // Holds the divisor 128.
    localparam int WWDT_POST_W       = 16; // Holds the ratio 32768.

    // ------------------------------------------------------------------
    // Power state of the core as seen by the watchdog.
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        WWDT_RUN   = 2'b00,
        WWDT_SLEEP = 2'b01,
        WWDT_IDLE  = 2'b10
    } wwdt_pstate_type;

endpackage

// ===== core/wwdt_pin_sync.sv
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/100ps
`default_nettype none
module wwdt_pin_sync
    import wwdt_pkg::*;
(
    // Clock, reset and enable.
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ce,
    // Asynchronous pin and filtered level.
    input  wire logic pin,
    output logic      level_q
);

    typedef struct packed {
        logic s1;    // First stage, read only by the second.
        logic s2;    // Second stage.
        logic s3;    // Third stage.
        logic level; // Accepted level.
    } wwdt_sync_type;

    wwdt_sync_type q;
    wwdt_sync_type d;

    // A change is accepted only once stages two and three agree.
    always_comb begin
        d    = q;
        d.s1 = pin;
        d.s2 = q.s1;
        d.s3 = q.s2;
        if (q.s2 == q.s3) begin
            d.level = q.s3;
        end
    end

    // State register, frozen while the clock enable is low.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    assign level_q = q.level;

endmodule
`default_nettype wire

// ===== core/wwdt_scale_counter.sv
// Modulo counter used for both the prescaler and the postscaler.
`timescale 1ns/100ps
`default_nettype none
module wwdt_scale_counter
    import wwdt_pkg::*;
#(
    parameter int W = 8
)(
    // Clock, reset and enable.
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    // Control.
    input  wire logic         clr,
    input  wire logic         inc,
    input  wire logic [W-1:0] limit,
    // Count and wrap.
    output logic [W-1:0]      count_q,
    output logic              carry
);

    typedef struct packed {
        logic [W-1:0] count; // Current count, 0 to limit-1.
    } wwdt_cnt_type;

    wwdt_cnt_type q;
    wwdt_cnt_type d;

    // A clear beats a count in the same cycle, so no carry escapes it.
    always_comb begin
        d     = q;
        carry = 1'b0;
        if (clr) begin
            d.count = '0;
        end else if (inc) begin
            if (q.count >= W'(limit - 1'b1)) begin
                d.count = '0;
                carry   = 1'b1;
            end else begin
                d.count = W'(q.count + 1'b1);
            end
        end
    end

    // State register, frozen while the clock enable is low.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    assign count_q = q.count;

endmodule
`default_nettype wire

// ===== core/wwdt_top.sv
// Windowed watchdog timer with AHB-Lite registers and power-save handling.
//
// Local design decisions: the register offsets and the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module wwdt_top
    import wwdt_pkg::*;
(
    // Clock, reset and clock enable.
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    // AHB-Lite slave.
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Core events, one-cycle pulses.
    input  wire logic        watchdog_clear_instr,
    input  wire logic        power_save_instr,
    input  wire logic        power_save_idle,
    input  wire logic        wake_event,
    input  wire logic        clock_switch_done,
    // Oscillator.
    input  wire logic        low_power_rc_osc,
    output logic             osc_enable,
    // Results.
    output logic             wdt_reset_req,
    output logic             wdt_wake
);

    // ------------------------------------------------------------------
    // State.
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]      cfg;        // Watchdog config word.
        logic            sw_en;      // Software enable.
        logic            tmo_flag;   // Sticky time-out flag.
        logic            sleep_flag; // Sticky woke-from-Sleep flag.
        logic            idle_flag;  // Sticky woke-from-Idle flag.
        wwdt_pstate_type pstate;     // Core power state.
        logic            osc_prev;   // Last oscillator level, for edges.
        logic            dph_act;    // Data phase pending.
        logic            dph_wr;     // Pending transfer is a write.
        logic [7:0]      dph_addr;   // Pending byte offset.
        logic [31:0]     rdata;      // Read data to the bus.
        logic            ready;      // Bus ready out.
        logic            resp;       // Bus response, always OKAY.
        logic            rst_req;    // Reset request pulse.
        logic            wake;       // Watchdog wake pulse.
        logic            osc_en;     // Oscillator enable.
    } wwdt_state_type;

    localparam wwdt_state_type WWDT_ST_RESET = '{
        cfg:        WWDT_CFG_RESET,
        sw_en:      WWDT_RESET_CONTROL_REG_RESET[WWDT_RESET_CONTROL_REG_SWEN_BIT],
        tmo_flag:   WWDT_RESET_CONTROL_REG_RESET[WWDT_RESET_CONTROL_REG_TMO_BIT],
        sleep_flag: WWDT_RESET_CONTROL_REG_RESET[WWDT_RESET_CONTROL_REG_SLEEP_BIT],
        idle_flag:  WWDT_RESET_CONTROL_REG_RESET[WWDT_RESET_CONTROL_REG_IDLE_BIT],
        pstate:     WWDT_RUN,
        osc_prev:   1'b0,
        dph_act:    1'b0,
        dph_wr:     1'b0,
        dph_addr:   8'h00,
        rdata:      32'h0000_0000,
        ready:      1'b1,
        resp:       1'b0,
        rst_req:    1'b0,
        wake:       1'b0,
        osc_en:     1'b0
    };

    wwdt_state_type q;
    wwdt_state_type d;

    // ------------------------------------------------------------------
    // Counter chain and derived terms.
    // ------------------------------------------------------------------
    logic                   osc_level;  // Filtered oscillator level.
    logic                   tick;       // One oscillator rising edge.
    logic                   en;         // Watchdog running.
    logic                   in_run;     // Core executing normally.
    logic                   long_pre;   // Divide by 128 selected.
    logic [3:0]             post_sel;   // Postscale select.
    logic [WWDT_PRE_W-1:0]  pre_lim;    // Prescaler divisor.
    logic [WWDT_POST_W-1:0] post_lim;   // Postscaler ratio.
    logic [WWDT_PRE_W-1:0]  pre_cnt;    // Prescaler count.
    logic [WWDT_POST_W-1:0] post_cnt;   // Postscaler count.
    logic                   pre_carry;  // Basic period elapsed.
    logic                   tmo;        // Full time-out elapsed.
    logic                   cnt_clr;    // Zero both counters.
    logic                   ps_entry;   // Accepted power-save entry.
    logic                   ps_exit;    // Leaving power save.
    logic                   clr_run;    // Clear instruction in run.
    logic                   win_open;   // Final quarter reached.
    logic                   win_bad;    // Clear came too early.
    logic [23:0]            elapsed;    // Ticks since last clear.
    logic [23:0]            period;     // Ticks per time-out.
    logic [25:0]            elapsed4;   // Four times elapsed.
    logic [25:0]            period3;    // Three times period.
    logic                   taken;      // Address phase accepted.
    logic                   reset_control_reg_wr;    // Reset control write now.

    wwdt_pin_sync u_osc_sync (
        .clk     (hclk),
        .rst_n   (hresetn),
        .ce      (ce),
        .pin     (low_power_rc_osc),
        .level_q (osc_level)
    );

    // Enable terms and the window arithmetic, from registered state and the core event inputs.
    always_comb begin
        en       = q.cfg[WWDT_CFG_HWEN_BIT] | q.sw_en;
        in_run   = (q.pstate == WWDT_RUN);
        tick     = osc_level & ~q.osc_prev & en;
        long_pre = q.cfg[WWDT_CFG_PRESEL_BIT];
        post_sel = q.cfg[WWDT_CFG_POST_LSB +: WWDT_CFG_POST_W];
        pre_lim  = long_pre ? WWDT_PRE_W'(WWDT_PRE_DIV_LONG)
                            : WWDT_PRE_W'(WWDT_PRE_DIV_SHORT);
        post_lim = WWDT_POST_W'(16'h0001 << post_sel);
        ps_entry = power_save_instr & in_run;
        clr_run  = watchdog_clear_instr & in_run;
        // Counts are powers of two, so shifting joins them exactly.
        elapsed  = long_pre
                 ? (({8'h00, post_cnt} << WWDT_PRE_SH_LONG)
                    | {16'h0000, pre_cnt})
                 : (({8'h00, post_cnt} << WWDT_PRE_SH_SHORT)
                    | {16'h0000, pre_cnt});
        period   = long_pre ? ({8'h00, post_lim} << WWDT_PRE_SH_LONG)
                            : ({8'h00, post_lim} << WWDT_PRE_SH_SHORT);
        elapsed4 = {elapsed, 2'b00};
        period3  = {1'b0, period, 1'b0} + {2'b00, period};
        win_open = (elapsed4 >= period3);
        win_bad  = clr_run & en & ~q.cfg[WWDT_CFG_WINDOW_DISABLE_BIT]
                 & ~win_open;
    end

    // A time-out wraps both counters to zero by itself, so only the outside
    // wake needs a clear here; reading tmo would loop through the clear pin.
    always_comb begin
        cnt_clr = ~en | clock_switch_done
                | ps_entry
                | (~in_run & wake_event)
                | clr_run;
    end

    wwdt_scale_counter #(.W(WWDT_PRE_W)) u_prescale (
        .clk     (hclk),
        .rst_n   (hresetn),
        .ce      (ce),
        .clr     (cnt_clr),
        .inc     (tick),
        .limit   (pre_lim),
        .count_q (pre_cnt),
        .carry   (pre_carry)
    );

    wwdt_scale_counter #(.W(WWDT_POST_W)) u_postscale (
        .clk     (hclk),
        .rst_n   (hresetn),
        .ce      (ce),
        .clr     (cnt_clr),
        .inc     (pre_carry),
        .limit   (post_lim),
        .count_q (post_cnt),
        .carry   (tmo)
    );

    // ------------------------------------------------------------------
    // Next state: bus slave first, hardware events last so they win.
    // ------------------------------------------------------------------
    always_comb begin
        d         = q;
        d.rst_req = 1'b0;
        d.wake    = 1'b0;
        d.resp    = 1'b0;
        d.osc_prev = osc_level;
        d.osc_en  = en;
        taken     = hsel & htrans[1] & hready;
        reset_control_reg_wr   = q.dph_act & q.dph_wr & (q.dph_addr == WWDT_OFS_RESET_CONTROL_REG);
        ps_exit   = ~in_run & (wake_event | tmo);
        // Data phase: one wait state, then write or read data.
        if (q.dph_act) begin
            d.dph_act = 1'b0;
            d.ready   = 1'b1;
            if (q.dph_wr) begin
                if (q.dph_addr == WWDT_OFS_RESET_CONTROL_REG) begin
                    d.sw_en      = hwdata[WWDT_RESET_CONTROL_REG_SWEN_BIT];
                    d.tmo_flag   = hwdata[WWDT_RESET_CONTROL_REG_TMO_BIT];
                    d.sleep_flag = hwdata[WWDT_RESET_CONTROL_REG_SLEEP_BIT];
                    d.idle_flag  = hwdata[WWDT_RESET_CONTROL_REG_IDLE_BIT];
                end else if (q.dph_addr == WWDT_OFS_CONFIG) begin
                    d.cfg = hwdata[7:0];
                end
            end else begin
                d.rdata = 32'h0000_0000;
                if (q.dph_addr == WWDT_OFS_RESET_CONTROL_REG) begin
                    d.rdata[WWDT_RESET_CONTROL_REG_SWEN_BIT]  = q.sw_en;
                    d.rdata[WWDT_RESET_CONTROL_REG_TMO_BIT]   = q.tmo_flag;
                    d.rdata[WWDT_RESET_CONTROL_REG_SLEEP_BIT] = q.sleep_flag;
                    d.rdata[WWDT_RESET_CONTROL_REG_IDLE_BIT]  = q.idle_flag;
                end else if (q.dph_addr == WWDT_OFS_CONFIG) begin
                    d.rdata[7:0] = q.cfg;
                end else if (q.dph_addr == WWDT_OFS_STATUS) begin
                    d.rdata[WWDT_STAT_PRE_LSB +: 7] = pre_cnt[6:0];
                    d.rdata[WWDT_STAT_POST_LSB +: 16] = post_cnt;
                    d.rdata[WWDT_STAT_PS_LSB +: 2] = q.pstate;
                    d.rdata[WWDT_STAT_EN_BIT] = en;
                end
            end
        end
        // Address phase: the wait state keeps read data coherent.
        if (taken) begin
            d.dph_act  = 1'b1;
            d.dph_wr   = hwrite;
            d.dph_addr = haddr[7:0];
            d.ready    = 1'b0;
        end
        // Power state tracking.
        case (q.pstate)
            WWDT_RUN: begin
                if (ps_entry) begin
                    d.pstate = power_save_idle ? WWDT_IDLE : WWDT_SLEEP;
                end
            end
            WWDT_SLEEP, WWDT_IDLE: begin
                if (ps_exit) begin
                    d.pstate = WWDT_RUN;
                end
            end
            default: begin
                d.pstate = WWDT_RUN;
            end
        endcase
        // Flags entered on power save; they stay until written.
        if (ps_entry & power_save_idle) begin
            d.idle_flag = 1'b1;
        end
        if (ps_entry & ~power_save_idle) begin
            d.sleep_flag = 1'b1;
        end
        // Time-out: reset in run, wake in power save.
        if (tmo) begin
            d.tmo_flag = 1'b1;
            if (in_run) begin
                d.rst_req = 1'b1;
            end else begin
                d.wake = 1'b1;
            end
        end
        if (win_bad) begin
            d.rst_req = 1'b1;
        end
    end

    // State register; the reset returns software enable to zero.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= WWDT_ST_RESET;
        end else if (ce) begin
            q <= d;
        end
    end

    assign hrdata        = q.rdata;
    assign hreadyout     = q.ready;
    assign hresp         = q.resp;
    assign osc_enable    = q.osc_en;
    assign wdt_reset_req = q.rst_req;
    assign wdt_wake      = q.wake;

    // ------------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------------
    sequence s_ps_entry;
        ce && power_save_instr && in_run;
    endsequence

    sequence s_counts_zero;
        (pre_cnt == '0) && (post_cnt == '0);
    endsequence

    a_osc_follows_en: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && en) |=> osc_enable)
        else $error("oscillator not enabled with watchdog");

    a_hw_forces_on: assert property (@(posedge hclk) disable iff (!hresetn)
        q.cfg[WWDT_CFG_HWEN_BIT] |-> en)
        else $error("hardware enable did not force watchdog on");

    a_switch_zeroes: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && clock_switch_done) |=> s_counts_zero)
        else $error("clock switch did not zero counts");

    a_entry_zeroes: assert property (@(posedge hclk) disable iff (!hresetn)
        s_ps_entry |=> s_counts_zero and !in_run)
        else $error("power-save entry did not zero counts");

    a_clear_zeroes: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && clr_run) |=> s_counts_zero)
        else $error("clear instruction did not zero counts");

    a_sleep_wake: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && tmo && !in_run) |=> wdt_wake && !wdt_reset_req && in_run)
        else $error("power-save time-out did not wake");

    a_run_reset: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && tmo && in_run) |=> wdt_reset_req && q.tmo_flag)
        else $error("run time-out did not request reset");

    a_flag_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && q.tmo_flag && !reset_control_reg_wr) |=> q.tmo_flag)
        else $error("time-out flag cleared without a write");

    a_sleep_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && q.sleep_flag && !reset_control_reg_wr) |=> q.sleep_flag)
        else $error("sleep flag cleared without a write");

    a_early_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && clr_run && en && !q.cfg[WWDT_CFG_WINDOW_DISABLE_BIT]
         && !win_open) |=> wdt_reset_req)
        else $error("early clear in window mode not punished");

    a_sw_stop: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && !q.cfg[WWDT_CFG_HWEN_BIT] && !q.sw_en) |=> s_counts_zero)
        else $error("disabled watchdog kept counting");

endmodule
`default_nettype wire

// ===== test/wwdt_core_model.sv
// Core-side model: oscillator pin and instruction pulses for the watchdog.
`timescale 1ns/100ps
`default_nettype none
module wwdt_core_model (
    // Clock and oscillator request.
    input  wire logic hclk,
    input  wire logic osc_enable,
    // Oscillator pin and core events.
    output logic      low_power_rc_osc,
    output logic      watchdog_clear_instr,
    output logic      power_save_instr,
    output logic      power_save_idle,
    output logic      clock_switch_done
);
    logic [1:0] div_q; // Fast pin: one toggle every fourth hclk edge.
    initial begin
        {low_power_rc_osc, watchdog_clear_instr, power_save_instr} = '0;
        {power_save_idle, clock_switch_done, div_q} = '0;
    end
    // The oscillator stands still unless the watchdog asks for it.
    always @(posedge hclk) begin
        if (osc_enable) begin
            div_q <= div_q + 2'h1;
            if (div_q == 2'h3)
                low_power_rc_osc <= ~low_power_rc_osc;
        end
    end
    // One-cycle event: 0 clear, 1 sleep, 2 idle, 3 clock switch done.
    // Callers leave an edge between pulses, so no signal is set twice.
    task automatic pulse(input int k);
        watchdog_clear_instr <= (k == 0);
        power_save_instr     <= (k == 1) || (k == 2);
        power_save_idle      <= (k == 2);
        clock_switch_done    <= (k == 3);
        @(posedge hclk);
        {watchdog_clear_instr, power_save_instr} <= '0;
        {power_save_idle, clock_switch_done} <= '0;
    endtask
endmodule
`default_nettype wire

// ===== test/testbench.sv
// Self-checking testbench of the windowed watchdog.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic        hclk, hresetn, hwrite, rdy, hresp, osc, osc_en;
    logic        clr, ps, ps_idle, csw, req, wake, got_wake, ce, wev;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, rd;
    int          failures, samples_checked, n;
    // ------------------------------------------------------------------
    // Clock, design and core model.
    // ------------------------------------------------------------------
    always #2.5 hclk = ~hclk;
    wwdt_top dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(rdy), .hrdata(hrdata), .hreadyout(rdy),
        .hresp(hresp), .watchdog_clear_instr(clr), .power_save_instr(ps),
        .power_save_idle(ps_idle), .wake_event(wev),
        .clock_switch_done(csw), .low_power_rc_osc(osc),
        .osc_enable(osc_en), .wdt_reset_req(req), .wdt_wake(wake));
    wwdt_core_model core (.hclk(hclk), .osc_enable(osc_en),
        .low_power_rc_osc(osc), .watchdog_clear_instr(clr),
        .power_save_instr(ps), .power_save_idle(ps_idle),
        .clock_switch_done(csw));
    // Counts every comparison and reports a mismatch at once.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One AHB-Lite single transfer; read data lands in rd.
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        haddr  <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge hclk); while (rdy !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (rdy !== 1'b1);
        rd = hrdata;
    endtask
    // Waits at most lim cycles for a reset request or a wake pulse.
    task automatic wait_out(input int lim);
        n = 0;
        while (n < lim && req !== 1'b1 && wake !== 1'b1) begin
            @(posedge hclk);
            n++;
        end
        got_wake = wake;
    endtask
    // Reset for two cycles, then reset values and the unmapped hole.
    task automatic t_reset();
        logic [31:0] ex[4] = '{32'h0, 32'h5f, 32'h0, 32'h0};
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, 8'(4 * i), 32'h0);
            chk(rd, ex[i]);
            chk(hresp, 1'b0);
        end
        $display("reset test done");
    endtask
    // Time-out length for three divider settings; a sticky flag follows.
    task automatic t_period();
        logic [7:0] cf[3] = '{8'h40, 8'h41, 8'h50};
        int         tk[3] = '{32, 64, 128};
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, 8'h04, {24'h0, cf[i]});
            bus(1'b1, 8'h00, 32'h20);
            core.pulse(0);
            wait_out(2000);
            chk(n > 8 * tk[i] - 12 && n < 8 * tk[i] + 12, 1);
            bus(1'b0, 8'h00, 32'h0);
            chk(rd[5:4], 2'h3);
            chk(osc_en, 1'b1);
        end
        $display("period test done");
    endtask
    // Clears and clock switches, well inside the period, hold off resets.
    task automatic t_clears();
        for (int k = 0; k <= 3; k += 3) begin
            bus(1'b1, 8'h00, 32'h20);
            repeat (8) begin
                core.pulse(k);
                wait_out(150);
                chk(req, 1'b0);
            end
        end
        bus(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h20);
        $display("clear test done");
    endtask
    // Time-out in Sleep and in Idle wakes the core instead of resetting.
    task automatic t_sleep();
        for (int k = 1; k <= 2; k++) begin
            bus(1'b1, 8'h00, 32'h20);
            core.pulse(k);
            wait_out(1100);
            chk(got_wake, 1'b1);
            bus(1'b0, 8'h00, 32'h0);
            chk(rd, (k == 1) ? 32'h38 : 32'h34);
            bus(1'b0, 8'h08, 32'h0);
            chk(rd[25:24], 2'h0);
        end
        $display("sleep test done");
    endtask
    // A low clock enable freezes Sleep; an outside wake leaves it quietly
    // and clears the counts, so no time-out follows soon after.
    task automatic t_hold();
        bus(1'b1, 8'h04, 32'h40);
        bus(1'b1, 8'h00, 32'h20);
        core.pulse(1);
        ce <= 1'b0;
        repeat (400) @(posedge hclk);
        ce <= 1'b1;
        bus(1'b0, 8'h08, 32'h0);
        chk(rd[25:24], 2'h1);
        repeat (200) @(posedge hclk);
        wev <= 1'b1;
        @(posedge hclk);
        wev <= 1'b0;
        wait_out(100);
        chk({req, wake}, 2'h0);
        bus(1'b0, 8'h08, 32'h0);
        chk(rd[25:24], 2'h0);
        $display("hold test done");
    endtask
    // Window mode: an early clear resets, a late one does not.
    task automatic t_window();
        bus(1'b1, 8'h04, 32'h00);
        core.pulse(0);
        repeat (20) @(posedge hclk);
        core.pulse(0);
        wait_out(6);
        chk(req, 1'b1);
        repeat (200) @(posedge hclk);
        core.pulse(0);
        wait_out(20);
        chk(req, 1'b0);
        $display("window test done");
    endtask
    // Hardware enable overrides software; with both off nothing runs.
    task automatic t_enable();
        bus(1'b1, 8'h04, 32'hc0);
        bus(1'b1, 8'h00, 32'h00);
        core.pulse(0);
        wait_out(400);
        chk(req, 1'b1);
        bus(1'b1, 8'h04, 32'h40);
        wait_out(400);
        chk({req, wake, osc_en}, 3'h0);
        $display("enable test done");
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Cuts a hang short; the tests need well under a third of this.
    initial begin
        repeat (30000) @(posedge hclk);
        failures++;
        final_report();
    end
    initial begin
        {hclk, hresetn, hwrite, htrans, haddr, hwdata, wev} = '0;
        ce = 1'b1;
        failures = 0;
        samples_checked = 0;
        @(posedge hclk);
        t_reset();
        t_period();
        t_clears();
        t_sleep();
        t_hold();
        t_window();
        t_enable();
        bus(1'b1, 8'h00, 32'h20);
        t_reset();
        final_report();
    end
endmodule
`default_nettype wire
